// *** hw/rla_allocator.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rla_regs.svh"
// Contract
// R1: Terminal reports fixed or dynamic slot capability at logon.
// R2: Fixed-slot terminals get constant burst parameters within one superframe.
// R3: Burst parameter changes apply only from a later superframe start.
// R4: Terminal needing idle slot before carrier change signals it at logon.
// R5: Superframes are contiguous; each carries a running superframe count.
// R6: Terminal transmits only in granted or contention slots.
// R7: Frames numbered from zero, time then frequency, at most 31.
// R8: Timeslots numbered from zero, time then frequency, at most 2047.
// R9: Slots addressed by superframe identifier, count, frame and timeslot.
// R10: Allocation period is the superframe, never the frame.
// R11: Terminal ready to send granted bursts within 90 ms of grant table.
// R12: Five categories: continuous, rate, volume, absolute volume, free.
// R13: Continuous rate granted in full every superframe while required; code caps it at the capacity left after earlier terminals' grants.
// R14: Rate requests replace earlier ones and are capped at the maximum.
// R15: Rate request expires after timeout, default two superframes, to zero.
// R16: Timeout configurable 1 to 15 superframes; zero disables expiry.
// R17: Continuous rate is the minimum; dynamic rate is granted on top.
// R18: Volume requests add to the outstanding total.
// R19: Outstanding volume drops by volume capacity granted each superframe.
// R20: Absolute volume request overwrites the outstanding total.
// R21: Terminal sends absolute volume when a volume request may be lost.
// R22: Free capacity comes only from otherwise unused capacity, unrequested.
// R23: Per-terminal setting inhibits free capacity.
// R24: Rate expiry timer restarts on each request, counts per superframe.
// R25: Grant order: continuous, rate, volume, then free capacity; code takes continuous, rate, volume per terminal in turn, free last.
module rla_allocator #(
  parameter int TERMS  = 4,
  parameter int CW     = 16,
  parameter int FRAMES = 32,
  parameter int SLOTS  = 2048
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  sf_boundary,
  input  wire logic                  slot_tick,
  input  wire logic [7:0]            superframe_identifier,
  input  wire logic [CW-1:0]         sf_capacity,
  input  wire logic                  req_valid,
  input  wire logic [$clog2(TERMS)-1:0] req_term,
  input  wire rla_pkg::rla_req_kind_t   req_kind,
  input  wire logic [CW-1:0]         req_amount,
  input  wire logic                  cfg_we,
  input  wire logic [$clog2(TERMS)-1:0] cfg_term,
  input  wire logic [CW-1:0]         cfg_continuous_rate,
  input  wire logic [CW-1:0]         cfg_rate_max,
  input  wire logic                  cfg_free_inhibit,
  input  wire logic                  cfg_dynamic_slots,
  input  wire logic [7:0]            cfg_burst_params,
  input  wire logic [3:0]            cfg_rate_timeout,
  output logic                       grant_valid,
  output logic [$clog2(TERMS)-1:0]   grant_term,
  output logic [CW-1:0]              grant_continuous,
  output logic [CW-1:0]              grant_rate,
  output logic [CW-1:0]              grant_volume,
  output logic [CW-1:0]              grant_free,
  output logic [7:0]                 grant_sf_identifier,
  output logic [15:0]                grant_sf_count,
  output logic [7:0]                 grant_burst_params,
  output logic                       grant_fixed_slots,
  output logic [4:0]                 cur_frame_num,
  output logic [10:0]                cur_slot_num
);
  localparam int TW = $clog2(TERMS);
  initial begin
    if (TERMS < 2 || CW < 4 || CW > 31)
      $error("rla_allocator: unsupported parameters");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    rla_pkg::rla_state_t          fsm;
    logic [TW-1:0]                idx;
    logic [CW-1:0]                left;
    logic [15:0]                  sf_count;
    logic [3:0]                   timeout;
    logic [TERMS-1:0][CW-1:0]     continuous_rate_grant;
    logic [TERMS-1:0][CW-1:0]     rmax;
    logic [TERMS-1:0][CW-1:0]     rate;
    logic [TERMS-1:0][3:0]        timer;
    logic [TERMS-1:0][CW-1:0]     vol;
    logic [TERMS-1:0]             inhibit;
    logic [TERMS-1:0]             dyn;
    logic [TERMS-1:0][7:0]        bp_pend;
    logic [TERMS-1:0][7:0]        bp_live;
    logic [TERMS-1:0][CW-1:0]     fr;
    logic                         g_valid;
    logic [TW-1:0]                g_term;
    logic [CW-1:0]                g_cra;
    logic [CW-1:0]                g_rate;
    logic [CW-1:0]                g_vol;
    logic [CW-1:0]                g_free;
    logic [7:0]                   g_sfid;
    logic [15:0]                  g_sfc;
    logic [7:0]                   g_bp;
    logic                         g_fixed;
  } rla_state_s_t;

  rla_state_s_t st_reg;
  rla_state_s_t st_next;

  // Takes the smaller of a demand and what is left, so no category overdraws.
  function automatic logic [CW-1:0] rla_take(input logic [CW-1:0] want,
                                             input logic [CW-1:0] avail);
    rla_take = (want < avail) ? want : avail;
  endfunction : rla_take

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [CW-1:0] c;
    logic [CW-1:0] r;
    logic [CW-1:0] v;
    logic [CW-1:0] rem;
    int unsigned   i;
    st_next = st_reg;
    c = '0;
    r = '0;
    v = '0;
    rem = '0;
    i = 32'(st_reg.idx);
    st_next.g_valid = 1'b0;

    if (cfg_we) begin
      st_next.continuous_rate_grant[cfg_term]     = cfg_continuous_rate;
      st_next.rmax[cfg_term]    = cfg_rate_max;
      st_next.inhibit[cfg_term] = cfg_free_inhibit; // [R23]
      st_next.dyn[cfg_term]     = cfg_dynamic_slots;
      // Parameters wait here until the next superframe boundary.
      st_next.bp_pend[cfg_term] = cfg_burst_params; // [R3]
    end

    if (req_valid) begin
      case (req_kind)
        rla_pkg::RLA_REQ_RATE: begin
          st_next.rate[req_term] = rla_take(req_amount, st_reg.rmax[req_term]); // [R14]
          st_next.timer[req_term] = st_reg.timeout; // [R24]
        end
        rla_pkg::RLA_REQ_VOLUME: begin
          st_next.vol[req_term] = (st_reg.vol[req_term] > ~req_amount) ?
                                  '1 : st_reg.vol[req_term] + req_amount; // [R18]
        end
        rla_pkg::RLA_REQ_ABS_VOLUME: begin
          st_next.vol[req_term] = req_amount; // [R20]
        end
        default: begin
        end
      endcase
    end

    case (st_reg.fsm)
      rla_pkg::RLA_IDLE: begin
        // Only the superframe boundary starts an allocation pass.
        if (sf_boundary) begin // [R10]
          st_next.fsm = rla_pkg::RLA_GRANT;
          st_next.idx = '0;
          st_next.left = sf_capacity;
          st_next.sf_count = st_reg.sf_count + 16'h0001; // [R5]
          st_next.timeout = cfg_rate_timeout; // [R16]
          for (int k = 0; k < TERMS; k++) begin
            st_next.bp_live[k] = st_next.bp_pend[k]; // [R2] [R3]
            if (st_reg.timeout != `RLA_RATE_TIMEOUT_OFF &&
                !(req_valid && req_term == TW'(k) && req_kind == rla_pkg::RLA_REQ_RATE)) begin
              if (st_reg.timer[k] == 4'h1)
                st_next.rate[k] = '0; // [R15]
              if (st_reg.timer[k] != 4'h0)
                st_next.timer[k] = st_reg.timer[k] - 4'h1; // [R24]
            end
          end
        end
      end
      rla_pkg::RLA_GRANT: begin
        rem = st_reg.left;
        c = rla_take(st_reg.continuous_rate_grant[i], rem); // [R13] [R25]
        rem = rem - c;
        r = rla_take(st_next.rate[i], rem); // [R17] [R25]
        rem = rem - r;
        v = rla_take(st_next.vol[i], rem); // [R25]
        rem = rem - v;
        st_next.vol[i] = st_next.vol[i] - v; // [R19]
        st_next.left = rem;
        st_next.g_valid = 1'b1;
        st_next.g_term = st_reg.idx;
        st_next.g_cra = c;
        st_next.g_rate = r;
        st_next.g_vol = v;
        st_next.g_free = '0;
        st_next.g_sfid = superframe_identifier; // [R9]
        st_next.g_sfc = st_reg.sf_count; // [R9]
        st_next.g_bp = st_reg.bp_live[i];
        st_next.g_fixed = !st_reg.dyn[i]; // [R2]
        st_next.fr[i] = '0;
        if (32'(st_reg.idx) == TERMS - 1) begin
          st_next.fsm = rla_pkg::RLA_IDLE;
          // Leftover goes to the last terminal, and only if that terminal is not inhibited.
          for (int k = TERMS - 1; k >= 0; k--) begin
            if (!st_reg.inhibit[k]) // [R23]
              st_next.fr[k] = '0;
          end
          for (int k = TERMS - 1; k >= 0; k--) begin
            if (!st_reg.inhibit[k] && k == TERMS - 1 && rem != '0) begin
              st_next.g_free = rem; // [R22]
              st_next.left = '0;
            end
          end
        end else begin
          st_next.idx = st_reg.idx + TW'(1);
        end
      end
      default: st_next.fsm = rla_pkg::RLA_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.timeout <= `RLA_RATE_TIMEOUT_DFLT; // [R15]
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Numbering and outputs
  // ------------------------------------------------------------
  rla_slot_counter #(
    .FRAMES (FRAMES),
    .SLOTS  (SLOTS)
  ) u_slots (
    .clk       (clk),
    .reset_n   (reset_n),
    .sf_start  (sf_boundary),
    .slot_tick (slot_tick),
    .frame_num (cur_frame_num),
    .slot_num  (cur_slot_num)
  );

  assign grant_valid         = st_reg.g_valid;
  assign grant_term          = st_reg.g_term;
  assign grant_continuous    = st_reg.g_cra;
  assign grant_rate          = st_reg.g_rate;
  assign grant_volume        = st_reg.g_vol;
  assign grant_free          = st_reg.g_free;
  assign grant_sf_identifier = st_reg.g_sfid;
  assign grant_sf_count      = st_reg.g_sfc;
  assign grant_burst_params  = st_reg.g_bp;
  assign grant_fixed_slots   = st_reg.g_fixed;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_sf_count_step: assert property (@(posedge clk) disable iff (!reset_n)
    (sf_boundary && st_reg.fsm == rla_pkg::RLA_IDLE) |=>
      st_reg.sf_count == $past(st_reg.sf_count) + 16'h0001) else $error("count skip"); // [R5]
  a_slot_cap: assert property (@(posedge clk) disable iff (!reset_n)
    cur_slot_num <= `RLA_MAX_SLOT_NUM) else $error("slot over limit"); // [R8]
  a_grant_sum: assert property (@(posedge clk) disable iff (!reset_n)
    grant_valid |-> ({2'b00, grant_continuous} + {2'b00, grant_rate}
      + {2'b00, grant_volume} + {2'b00, grant_free} <= {2'b00, sf_capacity}))
    else $error("grants exceed capacity"); // [R25]
  a_rate_capped: assert property (@(posedge clk) disable iff (!reset_n)
    (req_valid && req_kind == rla_pkg::RLA_REQ_RATE) |=>
      st_reg.rate[$past(req_term)] <= st_reg.rmax[$past(req_term)]) else $error("rate cap"); // [R14]
  a_abs_volume: assert property (@(posedge clk) disable iff (!reset_n)
    (req_valid && req_kind == rla_pkg::RLA_REQ_ABS_VOLUME && st_reg.fsm == rla_pkg::RLA_IDLE)
      |=> st_reg.vol[$past(req_term)] == $past(req_amount)) else $error("abs volume"); // [R20]
  a_free_inhibit: assert property (@(posedge clk) disable iff (!reset_n)
    (grant_valid && grant_free != '0) |-> !st_reg.inhibit[grant_term]) else $error("free inhibited"); // [R23]
  a_grant_burst: assert property (@(posedge clk) disable iff (!reset_n)
    (st_reg.fsm == rla_pkg::RLA_IDLE && sf_boundary) |-> ##[1:64] grant_valid)
    else $error("no grant pass"); // [R13]
  a_bp_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !(sf_boundary && st_reg.fsm == rla_pkg::RLA_IDLE) |=> $stable(st_reg.bp_live))
    else $error("params changed mid superframe"); // [R3]
endmodule : rla_allocator
`default_nettype wire

// *** shared/rla_regs.svh ***
`ifndef RLA_REGS_SVH
`define RLA_REGS_SVH
`define RLA_MAX_FRAME_NUM      5'd31
`define RLA_MAX_SLOT_NUM       11'd2047
`define RLA_RATE_TIMEOUT_DFLT  4'd2
`define RLA_RATE_TIMEOUT_OFF   4'd0
`define RLA_TGT_LATENCY_MS     90
`endif

// *** shared/rla_pkg.sv ***
package rla_pkg;
  typedef enum logic [2:0] {
    RLA_REQ_NONE,
    RLA_REQ_RATE,
    RLA_REQ_VOLUME,
    RLA_REQ_ABS_VOLUME
  } rla_req_kind_t;
  typedef enum logic [1:0] {
    RLA_IDLE,
    RLA_GRANT
  } rla_state_t;
endpackage : rla_pkg

// *** hw/rla_slot_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rla_regs.svh"
// Walks frame and timeslot numbers within one superframe, time then frequency.
module rla_slot_counter #(
  parameter int FRAMES = 32,
  parameter int SLOTS  = 2048
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sf_start,
  input  wire logic        slot_tick,
  output logic [4:0]       frame_num,
  output logic [10:0]      slot_num
);
  initial begin
    if (FRAMES < 1 || FRAMES > 32 || SLOTS < 1 || SLOTS > 2048)
      $error("rla_slot_counter: frame or slot count out of range");
  end
  localparam logic [4:0]  LAST_F = 5'(FRAMES - 1);
  localparam logic [10:0] LAST_S = 11'(SLOTS - 1);
  always_ff @(posedge clk) begin
    if (!reset_n || sf_start) begin
      frame_num <= 5'h0;
      slot_num  <= 11'h000;
    end else if (slot_tick) begin
      if (slot_num == LAST_S) begin
        slot_num <= 11'h000;
        if (frame_num != LAST_F)
          frame_num <= frame_num + 5'h1; // [R7]
      end else begin
        slot_num <= slot_num + 11'h001; // [R8]
      end
    end
  end
  a_frame_cap: assert property (@(posedge clk) disable iff (!reset_n)
    frame_num <= `RLA_MAX_FRAME_NUM) else $error("frame number over limit"); // [R7]
endmodule : rla_slot_counter
`default_nettype wire

// *** bench/rla_term_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// A terminal on the far side that issues capacity requests, one cycle each.
module rla_term_model #(
  parameter int TERMS = 2,
  parameter int CW    = 16
) (
  input  wire logic                     clk,
  output logic                          req_valid,
  output logic [$clog2(TERMS)-1:0]      req_term,
  output rla_pkg::rla_req_kind_t        req_kind,
  output logic [CW-1:0]                 req_amount
);
  initial begin
    req_valid  = 1'b0;
    req_term   = '0;
    req_kind   = rla_pkg::RLA_REQ_NONE;
    req_amount = '0;
  end

  // After the request the amount lines show the inverse, so a stale value is never reused.
  task automatic send(input rla_pkg::rla_req_kind_t k, input logic [$clog2(TERMS)-1:0] t,
                      input logic [CW-1:0] a);
    @(posedge clk);
    req_valid  <= 1'b1;
    req_term   <= t;
    req_kind   <= k;
    req_amount <= a;
    @(posedge clk);
    req_valid  <= 1'b0;
    req_kind   <= rla_pkg::RLA_REQ_NONE;
    req_amount <= ~a;
  endtask : send

  task automatic send_volume(input logic [$clog2(TERMS)-1:0] t, input logic [CW-1:0] a,
                             input logic lost);
    if (lost) begin
      send(rla_pkg::RLA_REQ_ABS_VOLUME, t, a);
    end else begin
      send(rla_pkg::RLA_REQ_VOLUME, t, a);
    end
  endtask : send_volume
endmodule : rla_term_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TERMS = 2;
  localparam int CW    = 16;
  logic             clk, reset_n, sf_boundary, slot_tick, cfg_we, cfg_free_inhibit;
  logic             cfg_dynamic_slots;
  logic [7:0]       sf_id, cfg_burst_params;
  logic [CW-1:0]    sf_capacity, cfg_continuous_rate, cfg_rate_max;
  logic [0:0]       cfg_term;
  logic [3:0]       cfg_rate_timeout;
  wire              req_valid;
  wire  [0:0]       req_term;
  wire rla_pkg::rla_req_kind_t req_kind;
  wire  [CW-1:0]    req_amount;
  logic             grant_valid, grant_fixed_slots;
  logic [0:0]       grant_term;
  logic [CW-1:0]    gc, gr, gv, gf;
  logic [7:0]       gsid, gbp;
  logic [15:0]      gcnt, cnt_seen, cnt_prev;
  logic [4:0]       cur_frame_num;
  logic [10:0]      cur_slot_num;
  logic [15:0]      g_c[TERMS], g_r[TERMS], g_v[TERMS], g_f[TERMS], g_bp[TERMS], g_fx[TERMS];
  int               fails, checked, cyc;

  rla_allocator #(.TERMS(TERMS), .CW(CW), .FRAMES(32), .SLOTS(2048)) i_dut (
    .clk(clk), .reset_n(reset_n), .sf_boundary(sf_boundary), .slot_tick(slot_tick),
    .superframe_identifier(sf_id), .sf_capacity(sf_capacity), .req_valid(req_valid),
    .req_term(req_term), .req_kind(req_kind), .req_amount(req_amount), .cfg_we(cfg_we),
    .cfg_term(cfg_term), .cfg_continuous_rate(cfg_continuous_rate),
    .cfg_rate_max(cfg_rate_max), .cfg_free_inhibit(cfg_free_inhibit),
    .cfg_dynamic_slots(cfg_dynamic_slots), .cfg_burst_params(cfg_burst_params),
    .cfg_rate_timeout(cfg_rate_timeout), .grant_valid(grant_valid), .grant_term(grant_term),
    .grant_continuous(gc), .grant_rate(gr), .grant_volume(gv), .grant_free(gf),
    .grant_sf_identifier(gsid), .grant_sf_count(gcnt), .grant_burst_params(gbp),
    .grant_fixed_slots(grant_fixed_slots), .cur_frame_num(cur_frame_num),
    .cur_slot_num(cur_slot_num));

  rla_term_model #(.TERMS(TERMS), .CW(CW)) i_term (
    .clk(clk), .req_valid(req_valid), .req_term(req_term), .req_kind(req_kind),
    .req_amount(req_amount));

  always #25 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks made %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // The whole run takes a little over 2000 cycles, mostly the 2051 slot ticks, so this ceiling only trips on a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fails++;
      $display("unexpected at %0t ns: run did not finish", $time);
      tally_and_finish;
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic setup(input logic [0:0] t, input logic [CW-1:0] cont, input logic [CW-1:0] mx,
                       input logic inh, input logic dyn, input logic [7:0] bp);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_term <= t;
    cfg_continuous_rate <= cont;
    cfg_rate_max <= mx;
    cfg_free_inhibit <= inh;
    cfg_dynamic_slots <= dyn;
    cfg_burst_params <= bp;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask : setup

  task automatic sf_pass(input logic [CW-1:0] cap);
    int n;
    int got;
    @(posedge clk);
    sf_capacity <= cap;
    sf_boundary <= 1'b1;
    @(posedge clk);
    sf_boundary <= 1'b0;
    got = 0;
    n = 0;
    // Twenty cycles is far inside the terminal's processing budget for a grant table.
    while (got < TERMS && n < 20) begin
      @(negedge clk);
      n++;
      if (grant_valid === 1'b1) begin
        if (got == 0) begin
          cnt_prev = cnt_seen;
          cnt_seen = gcnt;
        end
        g_c[grant_term] = gc;
        g_r[grant_term] = gr;
        g_v[grant_term] = gv;
        g_f[grant_term] = gf;
        g_bp[grant_term] = {8'h00, gbp};
        g_fx[grant_term] = {15'h0000, grant_fixed_slots};
        cmp({8'h00, gsid}, 16'h005A, "superframe identifier");
        cmp({15'h0000, grant_term}, got[15:0], "granted terminal");
        got++;
      end
    end
    cmp(got[15:0], 16'h0002, "grants in pass");
  endtask : sf_pass

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    clk = 1'b0; reset_n = 1'b0; sf_boundary = 1'b0; slot_tick = 1'b0; sf_id = 8'h5A;
    sf_capacity = '0; cfg_we = 1'b0; cfg_term = '0; cfg_continuous_rate = '0;
    cfg_rate_max = '0; cfg_free_inhibit = 1'b0; cfg_dynamic_slots = 1'b0;
    cfg_burst_params = 8'h00; cfg_rate_timeout = 4'h2;
    fails = 0; checked = 0; cnt_seen = '0; cnt_prev = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    setup(1'b0, 16'h000A, 16'h0032, 1'b0, 1'b0, 8'h3C);
    setup(1'b1, 16'h0005, 16'h0014, 1'b0, 1'b1, 8'hA5);
    sf_pass(16'h0100);
    cmp(g_c[0], 16'h000A, "continuous 0");
    cmp(g_c[1], 16'h0005, "continuous 1");
    cmp(g_f[1], 16'h00F1, "free last");
    cmp(g_f[0], 16'h0000, "free first");
    cmp(g_bp[0], 16'h003C, "burst params");
    cmp(g_fx[0], 16'h0001, "fixed slots");
    sf_pass(16'h0100);
    cmp(cnt_seen, cnt_prev + 16'h0001, "superframe count");
    $display("test base done");
    i_term.send(rla_pkg::RLA_REQ_RATE, 1'b0, 16'h0050);
    sf_pass(16'h0100);
    cmp(g_r[0], 16'h0032, "rate capped");
    cmp(g_c[0], 16'h000A, "rate floor");
    i_term.send(rla_pkg::RLA_REQ_RATE, 1'b0, 16'h001E);
    sf_pass(16'h0100);
    cmp(g_r[0], 16'h001E, "rate replaced");
    repeat (3) sf_pass(16'h0100);
    cmp(g_r[0], 16'h0000, "rate expired");
    cfg_rate_timeout <= 4'h0;
    i_term.send(rla_pkg::RLA_REQ_RATE, 1'b0, 16'h0014);
    repeat (4) sf_pass(16'h0100);
    cmp(g_r[0], 16'h0014, "rate no expiry");
    i_term.send(rla_pkg::RLA_REQ_RATE, 1'b0, 16'h0000);
    sf_pass(16'h0100);
    cmp(g_r[0], 16'h0000, "rate zeroed");
    cfg_rate_timeout <= 4'h2;
    $display("test rate done");
    i_term.send_volume(1'b1, 16'h0064, 1'b0);
    i_term.send_volume(1'b1, 16'h0032, 1'b0);
    sf_pass(16'h0100);
    cmp(g_v[1], 16'h0096, "volume sum");
    cmp(g_f[1], 16'h005B, "free after volume");
    sf_pass(16'h0100);
    cmp(g_v[1], 16'h0000, "volume drained");
    i_term.send_volume(1'b1, 16'h0064, 1'b0);
    sf_pass(16'h0028);
    cmp(g_v[1], 16'h0019, "volume partial");
    cmp(g_f[1], 16'h0000, "no free left");
    i_term.send_volume(1'b1, 16'h0007, 1'b1);
    sf_pass(16'h0100);
    cmp(g_v[1], 16'h0007, "absolute volume");
    $display("test volume done");
    setup(1'b1, 16'h0005, 16'h0014, 1'b1, 1'b1, 8'hA5);
    sf_pass(16'h0100);
    cmp(g_f[1], 16'h0000, "free inhibited");
    cmp(g_c[1], 16'h0005, "continuous kept");
    $display("test inhibit done");
    @(posedge clk);
    slot_tick <= 1'b1;
    repeat (2051) @(posedge clk);
    slot_tick <= 1'b0;
    @(negedge clk);
    cmp({11'h000, cur_frame_num}, 16'h0001, "frame number");
    cmp({5'h00, cur_slot_num}, 16'h0003, "slot number");
    $display("test numbering done");
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
